// ===== rtl/rtc_defs.svh
// Purpose: Register offsets, field positions, reset values and counts
// Assumes: Internal address space of four bits, eight-bit registers
// Notes: Included by every design module of the block; the package does not include it
`ifndef RTC_DEFS_SVH
`define RTC_DEFS_SVH

// Register offsets
`define ADDR_YEAR_BCD 4'h6
`define ADDR_TIME_TRIMMING 4'h7
`define ADDR_ALARM_A_MINUTE 4'h8
`define ADDR_ALARM_A_HOUR 4'h9
`define ADDR_ALARM_A_WEEKDAY_MASK 4'ha
`define ADDR_ALARM_B_MINUTE 4'hb
`define ADDR_ALARM_B_HOUR 4'hc
`define ADDR_ALARM_B_WEEKDAY_MASK 4'hd

// Field positions of the trimming register
`define TRIM_XSEL_BIT 7
`define TRIM_DIR_BIT 6
`define TRIM_MAG_MSB 5

// Reset values
`define TIME_TRIMMING_RESET 8'h00
`define YEAR_BCD_RESET 8'h00
`define ALARM_FIELD_RESET 7'h00
`define UNMAPPED_READ 8'h00

// Oscillator pulses per nominal second
`define PRESCALE_32768 16'h8000
`define PRESCALE_32000 16'h7d00

// Seconds values that open a trimmed second
`define TRIM_SEC_00 7'h00
`define TRIM_SEC_20 7'h20
`define TRIM_SEC_40 7'h40

`endif

// ===== rtl/rtc_pkg.sv
// Purpose: Types shared by the timekeeping register block
// Assumes: Nothing beyond the defs header
// Notes: Numbers live in rtc_defs.svh
package rtc_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [6:0] bcd_minute_t;
  typedef logic [5:0] bcd_hour_t;
  typedef logic [2:0] weekday_t;
  typedef enum logic {
    XTAL_32768 = 1'b0,
    XTAL_32000 = 1'b1
  } xtal_sel_t;
endpackage : rtc_pkg

// ===== rtl/trim_prescaler.sv
// Purpose: One-second prescaler with periodic trimming
// Assumes: osc_tick is a one-cycle pulse per crystal period
// Notes: Period is evaluated against the live seconds value
`timescale 1ns/1ps
`include "rtc_defs.svh"
module trim_prescaler
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Oscillator and seconds
  input wire logic osc_tick,
  input wire logic [6:0] seconds_bcd,
  // Trimming settings
  input wire xtal_sel_t crystal_freq_select,
  input wire logic trim_direction,
  input wire logic [5:0] trim_magnitude,
  // Second advance
  output logic sec_advance_r,
  output logic [15:0] period_r
);
  logic [15:0] cnt_r;
  logic [15:0] nominal;
  logic [15:0] period_nxt;
  logic trim_window;
  logic [7:0] lengthen;
  logic [7:0] shorten;

  // Period for the current second
  always_comb begin
    nominal = (crystal_freq_select == XTAL_32000) ? `PRESCALE_32000 : `PRESCALE_32768;
    trim_window = (seconds_bcd == `TRIM_SEC_00) || (seconds_bcd == `TRIM_SEC_20) ||
                  (seconds_bcd == `TRIM_SEC_40);
    lengthen = {1'b0, trim_magnitude - 6'h01, 1'b0};
    shorten = {{1'b0, ~trim_magnitude} + 7'h01, 1'b0};
    period_nxt = nominal;
    if (trim_window && (trim_magnitude[5:1] != 5'h00)) begin
      if (!trim_direction) begin
        period_nxt = nominal + {8'h00, lengthen};
      end else begin
        period_nxt = nominal - {8'h00, shorten};
      end
    end
  end

  // Pulse counter, wraps at the period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= 16'h0000;
      sec_advance_r <= 1'b0;
    end else if (ce) begin
      sec_advance_r <= 1'b0;
      if (osc_tick) begin
        if (cnt_r >= period_nxt - 16'h0001) begin
          cnt_r <= 16'h0000;
          sec_advance_r <= 1'b1;
        end else begin
          cnt_r <= cnt_r + 16'h0001;
        end
      end
    end
  end

  // Period seen by the checks only; not in the read map
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      period_r <= `PRESCALE_32768;
    end else if (ce) begin
      period_r <= period_nxt;
    end
  end

  sec_pulse_a: assert property (@(posedge clk) disable iff (!rst_b)
    sec_advance_r && ce |=> !sec_advance_r)
    else $error("second advance longer than one cycle");

  untrimmed_a: assert property (@(posedge clk) disable iff (!rst_b)
    !trim_window |-> period_nxt == nominal)
    else $error("trim applied outside trim seconds");

  trim_noop_a: assert property (@(posedge clk) disable iff (!rst_b)
    trim_magnitude[5:1] == 5'h00 |-> period_nxt == nominal)
    else $error("null trim changed the period");
endmodule : trim_prescaler

// ===== rtl/alarm_set.sv
// Purpose: One alarm set: minute, hour, weekday mask and match flag
// Assumes: Clock counters are stable BCD values
// Notes: Flag sets on the rising edge of a match
`timescale 1ns/1ps
`include "rtc_defs.svh"
module alarm_set
  import rtc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register writes
  input wire logic wr_minute,
  input wire logic wr_hour,
  input wire logic wr_mask,
  input wire reg_byte_t wdata,
  // Control
  input wire logic alarm_enable,
  input wire logic flag_clear,
  // Clock counters
  input wire bcd_minute_t minute_bcd,
  input wire bcd_hour_t hour_bcd,
  input wire weekday_t weekday_counter,
  // Stored fields and flag
  output bcd_minute_t minute_r,
  output bcd_hour_t hour_r,
  output logic [6:0] mask_r,
  output logic match_flag_r
);
  logic match;
  logic match_prev_r;

  // Minute, hour and mask equality
  always_comb begin
    match = (minute_bcd == minute_r) && (hour_bcd == hour_r) &&
            (weekday_counter != 3'h7) && mask_r[weekday_counter];
  end

  // Stored alarm fields, upper bits dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      minute_r <= `ALARM_FIELD_RESET;
      hour_r <= 6'h00;
      mask_r <= `ALARM_FIELD_RESET;
    end else if (ce) begin
      if (wr_minute) minute_r <= wdata[6:0];
      if (wr_hour) hour_r <= wdata[5:0];
      if (wr_mask) mask_r <= wdata[6:0];
    end
  end

  // Match flag; a new match wins over a clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      match_prev_r <= 1'b0;
      match_flag_r <= 1'b0;
    end else if (ce) begin
      match_prev_r <= match;
      if (!alarm_enable) begin
        match_flag_r <= 1'b0;
      end else if (match && !match_prev_r) begin
        match_flag_r <= 1'b1;
      end else if (flag_clear) begin
        match_flag_r <= 1'b0;
      end
    end
  end

  sequence match_start_s;
    ce && alarm_enable && match && !match_prev_r;
  endsequence

  flag_on_match_a: assert property (@(posedge clk) disable iff (!rst_b)
    match_start_s |=> match_flag_r)
    else $error("alarm flag missed a match");

  flag_off_disabled_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !alarm_enable |=> !match_flag_r)
    else $error("alarm flag set while disabled");

  mask_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    mask_r == 7'h00 |-> !match)
    else $error("alarm matched with empty weekday mask");
endmodule : alarm_set

// ===== rtl/rtc_year_trim_alarm_regs.sv
// Purpose: Year, time trimming and two alarm sets of a real-time clock
// Assumes: Register port strobes come from the serial bus decoder
// Notes: All inputs synchronous to clk; ce freezes every state element
`timescale 1ns/1ps
`include "rtc_defs.svh"
module rtc_year_trim_alarm_regs
  import rtc_pkg::*;
(
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire reg_byte_t reg_wdata,
  output reg_byte_t reg_rdata_r,
  // Oscillator
  input wire logic osc_tick,
  input wire logic crystal_clk_in,
  input wire logic oscillator_stopped_flag,
  output logic crystal_clk_out_r,
  // Clock counters
  input wire logic [6:0] seconds_bcd,
  input wire bcd_minute_t minute_bcd,
  input wire bcd_hour_t hour_bcd,
  input wire weekday_t weekday_counter,
  output logic sec_advance_r,
  // Alarm control
  input wire logic alarm_a_enable,
  input wire logic alarm_b_enable,
  input wire logic alarm_a_flag_clear,
  input wire logic alarm_b_flag_clear,
  output logic alarm_a_match_flag,
  output logic alarm_b_match_flag
);
  reg_byte_t year_digits_r;
  reg_byte_t time_trimming_r;
  reg_byte_t rdata_nxt;
  xtal_sel_t crystal_freq_select;
  logic trim_direction;
  logic [5:0] trim_magnitude;
  logic [15:0] period;
  logic wr_year;
  logic wr_trim;
  bcd_minute_t alarm_a_minute_digits;
  bcd_minute_t alarm_b_minute_digits;
  bcd_hour_t a_hour;
  bcd_hour_t b_hour;
  logic [6:0] alarm_a_weekday_enables;
  logic [6:0] alarm_b_weekday_enables;

  // Write strobes
  always_comb begin
    wr_year = reg_wr_en && (reg_addr == `ADDR_YEAR_BCD);
    wr_trim = reg_wr_en && (reg_addr == `ADDR_TIME_TRIMMING);
  end

  // Trimming fields
  always_comb begin
    crystal_freq_select = xtal_sel_t'(time_trimming_r[`TRIM_XSEL_BIT]);
    trim_direction = time_trimming_r[`TRIM_DIR_BIT];
    trim_magnitude = time_trimming_r[`TRIM_MAG_MSB:0];
  end

  // Year digits; content kept across oscillator stop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      year_digits_r <= `YEAR_BCD_RESET;
    end else if (ce && wr_year) begin
      year_digits_r <= reg_wdata;
    end
  end

  // Trimming register, forced to default while oscillator stopped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      time_trimming_r <= `TIME_TRIMMING_RESET;
    end else if (ce) begin
      if (oscillator_stopped_flag) begin
        time_trimming_r <= `TIME_TRIMMING_RESET;
      end else if (wr_trim) begin
        time_trimming_r <= reg_wdata;
      end
    end
  end

  // Crystal clock passes through untouched by trimming
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      crystal_clk_out_r <= 1'b0;
    end else if (ce) begin
      crystal_clk_out_r <= crystal_clk_in;
    end
  end

  // One-second prescaler
  trim_prescaler u_prescaler (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .osc_tick(osc_tick),
    .seconds_bcd(seconds_bcd),
    .crystal_freq_select(crystal_freq_select),
    .trim_direction(trim_direction),
    .trim_magnitude(trim_magnitude),
    .sec_advance_r(sec_advance_r),
    .period_r(period)
  );

  // Alarm set A
  alarm_set u_alarm_a (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_minute(reg_wr_en && (reg_addr == `ADDR_ALARM_A_MINUTE)),
    .wr_hour(reg_wr_en && (reg_addr == `ADDR_ALARM_A_HOUR)),
    .wr_mask(reg_wr_en && (reg_addr == `ADDR_ALARM_A_WEEKDAY_MASK)),
    .wdata(reg_wdata),
    .alarm_enable(alarm_a_enable),
    .flag_clear(alarm_a_flag_clear),
    .minute_bcd(minute_bcd),
    .hour_bcd(hour_bcd),
    .weekday_counter(weekday_counter),
    .minute_r(alarm_a_minute_digits),
    .hour_r(a_hour),
    .mask_r(alarm_a_weekday_enables),
    .match_flag_r(alarm_a_match_flag)
  );

  // Alarm set B
  alarm_set u_alarm_b (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .wr_minute(reg_wr_en && (reg_addr == `ADDR_ALARM_B_MINUTE)),
    .wr_hour(reg_wr_en && (reg_addr == `ADDR_ALARM_B_HOUR)),
    .wr_mask(reg_wr_en && (reg_addr == `ADDR_ALARM_B_WEEKDAY_MASK)),
    .wdata(reg_wdata),
    .alarm_enable(alarm_b_enable),
    .flag_clear(alarm_b_flag_clear),
    .minute_bcd(minute_bcd),
    .hour_bcd(hour_bcd),
    .weekday_counter(weekday_counter),
    .minute_r(alarm_b_minute_digits),
    .hour_r(b_hour),
    .mask_r(alarm_b_weekday_enables),
    .match_flag_r(alarm_b_match_flag)
  );

  // Read multiplexer; unused upper bits read zero
  always_comb begin
    unique case (reg_addr)
      `ADDR_YEAR_BCD: rdata_nxt = year_digits_r;
      `ADDR_TIME_TRIMMING: rdata_nxt = time_trimming_r;
      `ADDR_ALARM_A_MINUTE: rdata_nxt = {1'b0, alarm_a_minute_digits};
      `ADDR_ALARM_A_HOUR: rdata_nxt = {2'b00, a_hour};
      `ADDR_ALARM_A_WEEKDAY_MASK: rdata_nxt = {1'b0, alarm_a_weekday_enables};
      `ADDR_ALARM_B_MINUTE: rdata_nxt = {1'b0, alarm_b_minute_digits};
      `ADDR_ALARM_B_HOUR: rdata_nxt = {2'b00, b_hour};
      `ADDR_ALARM_B_WEEKDAY_MASK: rdata_nxt = {1'b0, alarm_b_weekday_enables};
      default: rdata_nxt = `UNMAPPED_READ;
    endcase
  end

  // Read data register, loaded on a read strobe
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_r <= `UNMAPPED_READ;
    end else if (ce && reg_rd_en) begin
      reg_rdata_r <= rdata_nxt;
    end
  end

  sequence year_write_s;
    ce && wr_year && !reg_rd_en;
  endsequence

  year_readback_a: assert property (@(posedge clk) disable iff (!rst_b)
    year_write_s ##1 (ce && !wr_year) ##1
    (ce && reg_rd_en && reg_addr == `ADDR_YEAR_BCD && !reg_wr_en)
    |=> reg_rdata_r == $past(reg_wdata, 3))
    else $error("year register lost a write");

  trim_stop_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && oscillator_stopped_flag |=> time_trimming_r == `TIME_TRIMMING_RESET)
    else $error("trimming not cleared on oscillator stop");

  upper_bits_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_rd_en && (reg_addr == `ADDR_ALARM_A_HOUR || reg_addr == `ADDR_ALARM_B_HOUR)
    |=> reg_rdata_r[7:6] == 2'b00)
    else $error("alarm hour upper bits not zero");

  minute_bit7_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_rd_en && reg_addr == `ADDR_ALARM_B_MINUTE |=> !reg_rdata_r[7])
    else $error("alarm minute bit 7 not zero");

  crystal_pass_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && rst_b |=> crystal_clk_out_r == $past(crystal_clk_in))
    else $error("crystal clock output altered");

  xtal_period_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && seconds_bcd == 7'h01 && crystal_freq_select == XTAL_32000
    ##1 seconds_bcd == 7'h01 |-> period == `PRESCALE_32000)
    else $error("wrong nominal count for 32.000 kHz");

  // Clock-enable freeze of local state
  year_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(year_digits_r))
    else $error("year register changed while frozen");

  trim_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(time_trimming_r))
    else $error("trimming register changed while frozen");

  crystal_freeze_a: assert property (@(posedge clk) disable iff (!rst_b)
    !ce |=> $stable(crystal_clk_out_r))
    else $error("crystal output changed while frozen");

  rdata_hold_a: assert property (@(posedge clk) disable iff (!rst_b)
    !(ce && reg_rd_en) |=> $stable(reg_rdata_r))
    else $error("read data changed without a read");

  // Register stores
  sequence trim_write_s;
    ce && wr_trim && !oscillator_stopped_flag;
  endsequence

  year_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && wr_year |=> year_digits_r == $past(reg_wdata))
    else $error("year write not stored");

  trim_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    trim_write_s |=> time_trimming_r == $past(reg_wdata))
    else $error("trimming write not stored");

  a_minute_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_wr_en && reg_addr == `ADDR_ALARM_A_MINUTE
    |=> {1'b0, alarm_a_minute_digits} == ($past(reg_wdata) & 8'h7f))
    else $error("alarm minute write not stored");

  b_hour_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_wr_en && reg_addr == `ADDR_ALARM_B_HOUR
    |=> {2'b00, b_hour} == ($past(reg_wdata) & 8'h3f))
    else $error("alarm hour write not stored");

  a_mask_store_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_wr_en && reg_addr == `ADDR_ALARM_A_WEEKDAY_MASK
    |=> {1'b0, alarm_a_weekday_enables} == ($past(reg_wdata) & 8'h7f))
    else $error("weekday mask write not stored");

  // Read values of unused bits and addresses
  mask_bit7_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_rd_en && (reg_addr == `ADDR_ALARM_A_WEEKDAY_MASK ||
    reg_addr == `ADDR_ALARM_B_WEEKDAY_MASK) |=> !reg_rdata_r[7])
    else $error("weekday mask bit 7 not zero");

  a_minute_bit7_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_rd_en && reg_addr == `ADDR_ALARM_A_MINUTE |=> !reg_rdata_r[7])
    else $error("alarm minute bit 7 not zero");

  unmapped_read_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && reg_rd_en && reg_addr > `ADDR_ALARM_B_WEEKDAY_MASK
    |=> reg_rdata_r == `UNMAPPED_READ)
    else $error("unmapped address read not zero");

  // Prescale counts for known settings
  sequence nominal_32768_s;
    ce && crystal_freq_select == XTAL_32768 && trim_magnitude[5:1] == 5'h00;
  endsequence

  sequence lengthen_7_s;
    ce && seconds_bcd == `TRIM_SEC_20 && time_trimming_r == 8'h07;
  endsequence

  sequence shorten_2_s;
    ce && seconds_bcd == `TRIM_SEC_40 && time_trimming_r == 8'hfe;
  endsequence

  nominal_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    nominal_32768_s |=> period == `PRESCALE_32768)
    else $error("untrimmed count not nominal");

  lengthen_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    lengthen_7_s |=> period == `PRESCALE_32768 + 16'h000c)
    else $error("lengthened count wrong");

  shorten_count_a: assert property (@(posedge clk) disable iff (!rst_b)
    shorten_2_s |=> period == `PRESCALE_32000 - 16'h0004)
    else $error("shortened count wrong");

  // Alarm set B flag at the block boundary
  empty_mask_b_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && alarm_b_weekday_enables == 7'h00 && !alarm_b_match_flag |=> !alarm_b_match_flag)
    else $error("alarm flag rose with empty mask");

  flag_b_disabled_a: assert property (@(posedge clk) disable iff (!rst_b)
    ce && !alarm_b_enable |=> !alarm_b_match_flag)
    else $error("disabled alarm flag not zero");
endmodule : rtc_year_trim_alarm_regs

// ===== tb/host_port_model.sv
// Purpose: Host side of the register port, single-byte reads and writes
// Assumes: Strobes are taken on the rising clk edge
// Notes: Released write data shows the inverse of its last value
`timescale 1ns/1ps
module host_port_model
  import rtc_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output logic [3:0] reg_addr,
  output logic reg_wr_en,
  output logic reg_rd_en,
  output reg_byte_t reg_wdata,
  input wire reg_byte_t reg_rdata_r
);
  // Idle port at time zero
  initial begin
    reg_addr = 4'h0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_wdata = 8'h00;
  end

  // One byte write, strobe held over one taking edge
  task automatic write_reg(input logic [3:0] addr, input reg_byte_t data);
    @(posedge clk);
    reg_addr <= addr;
    reg_wdata <= data;
    reg_wr_en <= 1'b1;
    @(posedge clk);
    reg_wr_en <= 1'b0;
    reg_wdata <= ~data; // Stale data must not look valid
  endtask : write_reg

  // One byte read, data registered at the taking edge
  task automatic read_reg(input logic [3:0] addr, output reg_byte_t data);
    @(posedge clk);
    reg_addr <= addr;
    reg_rd_en <= 1'b1;
    @(posedge clk);
    reg_rd_en <= 1'b0;
    #1;
    data = reg_rdata_r;
  endtask : read_reg
endmodule : host_port_model

// ===== tb/tb_rtc_year_trim_alarm_regs.sv
// Purpose: Self-checking bench for year, trimming and alarm registers
// Assumes: Host model drives the register port
// Notes: Oscillator ticks every clk so a second is about 33k cycles
`timescale 1ns/1ps
`include "rtc_defs.svh"
module tb_rtc_year_trim_alarm_regs
  import rtc_pkg::*;
();
  logic clk, rst_b, ce, osc_tick, crystal_clk_in, oscillator_stopped_flag;
  logic [6:0] seconds_bcd;
  bcd_minute_t minute_bcd;
  bcd_hour_t hour_bcd;
  weekday_t weekday_counter;
  logic alarm_a_enable, alarm_b_enable, alarm_a_flag_clear, alarm_b_flag_clear;
  logic [3:0] reg_addr;
  logic reg_wr_en, reg_rd_en, crystal_clk_out_r, sec_advance_r;
  logic alarm_a_match_flag, alarm_b_match_flag;
  reg_byte_t reg_wdata, reg_rdata_r;
  reg_byte_t rmask[6] = '{8'h7f, 8'h3f, 8'h7f, 8'h7f, 8'h3f, 8'h7f};
  int failures = 0;
  int n_compared = 0;
  int cyc = 0;
  int t0, t1;

  // Clock and cycle count
  always #2 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  // Crystal level toggles every cycle
  always @(posedge clk) crystal_clk_in <= ~crystal_clk_in;

  host_port_model u_host_port_model (.clk(clk), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r));

  rtc_year_trim_alarm_regs u_rtc_year_trim_alarm_regs (.clk(clk), .rst_b(rst_b), .ce(ce),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r), .osc_tick(osc_tick),
    .crystal_clk_in(crystal_clk_in), .oscillator_stopped_flag(oscillator_stopped_flag),
    .crystal_clk_out_r(crystal_clk_out_r), .seconds_bcd(seconds_bcd),
    .minute_bcd(minute_bcd), .hour_bcd(hour_bcd), .weekday_counter(weekday_counter),
    .sec_advance_r(sec_advance_r), .alarm_a_enable(alarm_a_enable),
    .alarm_b_enable(alarm_b_enable), .alarm_a_flag_clear(alarm_a_flag_clear),
    .alarm_b_flag_clear(alarm_b_flag_clear), .alarm_a_match_flag(alarm_a_match_flag),
    .alarm_b_match_flag(alarm_b_match_flag));

  // Verdict and end of run
  task automatic test_done;
    $display("Compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input reg_byte_t d);
    u_host_port_model.write_reg(a, d);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input reg_byte_t exp);
    reg_byte_t d;
    u_host_port_model.read_reg(a, d);
    chk({24'h0, d}, {24'h0, exp});
  endtask : rd_chk

  // Drive clock counters, let the flags settle, check both
  task automatic set_time(input bcd_minute_t m, input bcd_hour_t h, input weekday_t w,
                          input logic fa, input logic fb);
    @(posedge clk);
    minute_bcd <= m;
    hour_bcd <= h;
    weekday_counter <= w;
    repeat (3) @(posedge clk);
    #1;
    chk({31'h0, alarm_a_match_flag}, {31'h0, fa});
    chk({31'h0, alarm_b_match_flag}, {31'h0, fb});
  endtask : set_time

  // Wait for the seconds advance pulse, crystal output checked meanwhile
  task automatic wait_pulse(output int at);
    int k;
    for (k = 0; k < 40000; k++) begin
      @(posedge clk);
      #1;
      chk({31'h0, crystal_clk_out_r}, {31'h0, ~crystal_clk_in});
      if (sec_advance_r === 1'b1) break;
    end
    if (k == 40000) begin
      failures++;
      test_done();
    end
    at = cyc;
  endtask : wait_pulse

  // Main sequence
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    ce = 1'b1;
    osc_tick = 1'b0;
    crystal_clk_in = 1'b0;
    oscillator_stopped_flag = 1'b0;
    seconds_bcd = 7'h00;
    minute_bcd = 7'h00;
    hour_bcd = 6'h00;
    weekday_counter = 3'h0;
    alarm_a_enable = 1'b0;
    alarm_b_enable = 1'b0;
    alarm_a_flag_clear = 1'b0;
    alarm_b_flag_clear = 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd_chk(`ADDR_TIME_TRIMMING, 8'h00);
    wr(`ADDR_YEAR_BCD, 8'ha5);
    rd_chk(`ADDR_YEAR_BCD, 8'ha5);
    // Frozen clock enable drops a write
    @(posedge clk);
    ce <= 1'b0;
    wr(`ADDR_YEAR_BCD, 8'h5a);
    ce <= 1'b1;
    rd_chk(`ADDR_YEAR_BCD, 8'ha5);
    // Unused upper bits of the alarm registers read zero
    for (int i = 0; i < 6; i++) begin
      wr(4'h8 + i[3:0], 8'hff);
      rd_chk(4'h8 + i[3:0], rmask[i]);
    end
    wr(4'he, 8'h55);
    rd_chk(4'he, 8'h00);
    wr(`ADDR_TIME_TRIMMING, 8'h87);
    rd_chk(`ADDR_TIME_TRIMMING, 8'h87);
    // Stopped oscillator forces trimming to zero and refuses writes
    @(posedge clk);
    oscillator_stopped_flag <= 1'b1;
    rd_chk(`ADDR_TIME_TRIMMING, 8'h00);
    wr(`ADDR_TIME_TRIMMING, 8'h55);
    rd_chk(`ADDR_TIME_TRIMMING, 8'h00);
    rd_chk(`ADDR_ALARM_A_HOUR, 8'h3f);
    @(posedge clk);
    oscillator_stopped_flag <= 1'b0;
    // Alarm A at 12-hour noon, 30 minutes, weekday 1; alarm B empty mask
    wr(`ADDR_ALARM_A_MINUTE, 8'h30);
    wr(`ADDR_ALARM_A_HOUR, 8'h32);
    wr(`ADDR_ALARM_A_WEEKDAY_MASK, 8'h02);
    wr(`ADDR_ALARM_B_MINUTE, 8'h30);
    wr(`ADDR_ALARM_B_HOUR, 8'h32);
    wr(`ADDR_ALARM_B_WEEKDAY_MASK, 8'h00);
    @(posedge clk);
    alarm_a_enable <= 1'b1;
    alarm_b_enable <= 1'b1;
    set_time(7'h30, 6'h32, 3'h2, 1'b0, 1'b0);
    set_time(7'h30, 6'h12, 3'h1, 1'b0, 1'b0);
    set_time(7'h30, 6'h32, 3'h1, 1'b1, 1'b0);
    @(posedge clk);
    alarm_a_flag_clear <= 1'b1;
    @(posedge clk);
    alarm_a_flag_clear <= 1'b0;
    set_time(7'h30, 6'h32, 3'h1, 1'b0, 1'b0);
    set_time(7'h31, 6'h32, 3'h1, 1'b0, 1'b0);
    set_time(7'h30, 6'h32, 3'h1, 1'b1, 1'b0);
    @(posedge clk);
    alarm_a_enable <= 1'b0;
    set_time(7'h30, 6'h32, 3'h1, 1'b0, 1'b0);
    // Prescaler: one free second, then two measured trimmed seconds
    @(posedge clk);
    osc_tick <= 1'b1;
    wait_pulse(t0);
    wr(`ADDR_TIME_TRIMMING, 8'h07);
    seconds_bcd <= 7'h20;
    wait_pulse(t1);
    chk(t1 - t0, 32'd32780);
    wr(`ADDR_TIME_TRIMMING, 8'hfe);
    seconds_bcd <= 7'h40;
    wait_pulse(t0);
    chk(t0 - t1, 32'd31996);
    // Plain second at the 32.000 kHz setting
    seconds_bcd <= 7'h01;
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule : tb_rtc_year_trim_alarm_regs
